// ### hdl/crce_fifo.sv
// crce_fifo: small synchronous fifo with valid/ready on both sides.
// assumes one clock; depth must be a power of two.
`timescale 1ns/1ns
module crce_fifo #(
   parameter int WIDTH = 34,
   parameter int DEPTH = 8
) (
   input wire logic clk, // system clock
   input wire logic nrst, // async reset, active low
   input wire logic in_valid, // producer offers a word
   output logic in_ready, // room for a word
   input wire logic [WIDTH-1:0] in_data, // word written
   output logic out_valid, // a word is waiting
   input wire logic out_ready, // consumer takes it
   output logic [WIDTH-1:0] out_data // oldest word
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wp_q;
   logic [AW:0] rp_q;

   wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
   wire empty = (wp_q == rp_q);
   wire push = in_valid && !full;
   wire pop = out_ready && !empty;

   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem_q[rp_q[AW-1:0]];

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wp_q[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
      end
   end
endmodule

// ### hdl/crce_pkg.sv
// crce_pkg: shared types and constants of the checksum engine.
// assumes a single 100 MHz clock domain; no software-visible register map.
package crce_pkg;

   typedef enum logic [1:0] {
      CRCE_POLY_CCITT,
      CRCE_POLY_16,
      CRCE_POLY_32
   } crce_poly_t;

   typedef enum logic [1:0] {
      CRCE_SZ_BYTE,
      CRCE_SZ_HALF,
      CRCE_SZ_WORD
   } crce_size_t;

   typedef struct packed {
      logic [31:0] data;
      crce_size_t size;
   } crce_item_t;

   typedef struct packed {
      crce_poly_t poly;
      logic in_rev;
      logic in_inv;
      logic out_rev;
      logic out_inv;
   } crce_cfg_t;

   localparam logic [31:0] CRCE_POLY_CCITT_VAL = 32'h0000_1021;
   localparam logic [31:0] CRCE_POLY_16_VAL = 32'h0000_8005;
   localparam logic [31:0] CRCE_POLY_32_VAL = 32'h04c1_1db7;
   localparam logic [31:0] CRCE_MASK16 = 32'h0000_ffff;
   localparam logic [31:0] CRCE_MASK32 = 32'hffff_ffff;
   localparam logic [31:0] CRCE_RST_SUM = 32'h0000_0000;
   localparam logic [1:0] CRCE_LAST_BYTE = 2'h0;
   localparam logic [1:0] CRCE_LAST_HALF = 2'h1;
   localparam logic [1:0] CRCE_LAST_WORD = 2'h3;
   localparam int CRCE_FIFO_DEPTH = 8;
   localparam int CRCE_SHIFT16 = 16;

endpackage

// ### hdl/crce_top.sv
// crce_top: checksum engine folding written data into a running crc, one byte per cycle.
// assumes writer and reader are logic on the same clock; config stays stable while busy.
//
// Summary of operation
// RULE_01: polynomial selectable among ccitt 16-bit, crc-16 and 32-bit ethernet.
// RULE_02: input data optionally bit-reversed and complemented before entering the sum.
// RULE_03: presented result optionally bit-reversed and complemented.
// RULE_04: software loads a seed that becomes the starting sum.
// RULE_05: a byte write is absorbed in one clock cycle.
// RULE_06: a halfword write takes two byte steps, two cycles.
// RULE_07: a word write takes four byte steps, four cycles.
// RULE_08: back-to-back writes are accepted without polling.
// RULE_09: byte, halfword or word writes; exactly the written bytes are processed.
// RULE_10: writes are held off while the fifo is full; seed loads and result reads while earlier bytes are pending.
// RULE_11: bytes go least significant first; a new seed discards the old sum.
`timescale 1ns/1ns
module crce_top (
   input wire logic clk, // system clock, 100 MHz
   input wire logic nrst, // async reset, active low
   input wire crce_pkg::crce_cfg_t cfg, // polynomial and bit options
   input wire logic seed_valid, // seed load request
   output logic seed_ready, // seed load accepted when high
   input wire logic [31:0] seed, // seed value
   input wire logic wr_valid, // data write request
   output logic wr_ready, // data write accepted when high
   input wire crce_pkg::crce_item_t wr_item, // data and write width
   input wire logic rd_valid, // result read request
   output logic rd_ready, // result read completes when high
   output logic [31:0] result, // conditioned checksum
   output logic busy // bytes still pending
);
   typedef enum logic {CRCE_IDLE, CRCE_RUN} crce_state_t;

   crce_state_t state_q;
   crce_state_t state_d;
   logic [31:0] word_q;
   logic [1:0] idx_q;
   logic [1:0] last_q;
   logic [31:0] crc_q;
   logic [31:0] crc_d;
   logic [31:0] result_q;

   logic f_valid;
   crce_pkg::crce_item_t f_item;
   logic f_pop;

   function automatic logic [7:0] rev8(input logic [7:0] b);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 8; i++) begin
         r[i] = b[7-i];
      end
      return r;
   endfunction

   function automatic logic [31:0] rev32(input logic [31:0] w);
      logic [31:0] r;
      r = '0;
      for (int i = 0; i < 32; i++) begin
         r[i] = w[31-i];
      end
      return r;
   endfunction

   // msb-first shift of one byte through the selected polynomial
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b,
                                            input crce_pkg::crce_poly_t sel);
      logic [31:0] r;
      logic [31:0] p;
      logic fb;
      logic wide;
      r = c;
      wide = 1'b0;
      unique case (sel)
         crce_pkg::CRCE_POLY_CCITT: p = crce_pkg::CRCE_POLY_CCITT_VAL;
         crce_pkg::CRCE_POLY_16: p = crce_pkg::CRCE_POLY_16_VAL;
         default: begin
            p = crce_pkg::CRCE_POLY_32_VAL;
            wide = 1'b1;
         end
      endcase
      for (int i = 0; i < 8; i++) begin
         fb = (wide ? r[31] : r[15]) ^ b[7-i];
         r = {r[30:0], 1'b0} ^ (fb ? p : 32'h0000_0000);
      end
      return wide ? r : (r & crce_pkg::CRCE_MASK16);
   endfunction

   wire is32 = (cfg.poly != crce_pkg::CRCE_POLY_CCITT) && (cfg.poly != crce_pkg::CRCE_POLY_16);
   wire [31:0] width_mask = is32 ? crce_pkg::CRCE_MASK32 : crce_pkg::CRCE_MASK16;

   crce_fifo #(
      .WIDTH($bits(crce_pkg::crce_item_t)),
      .DEPTH(crce_pkg::CRCE_FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .nrst(nrst),
      .in_valid(wr_valid),
      .in_ready(wr_ready), // [RULE_08] [RULE_10]
      .in_data(wr_item),
      .out_valid(f_valid),
      .out_ready(f_pop),
      .out_data(f_item)
   );

   // input conditioning: complement, then reverse bits inside each byte
   wire [31:0] in_inv = cfg.in_inv ? ~f_item.data : f_item.data; // [RULE_02]
   wire [31:0] in_cond = cfg.in_rev ? {rev8(in_inv[31:24]), rev8(in_inv[23:16]),
                                       rev8(in_inv[15:8]), rev8(in_inv[7:0])}
                                    : in_inv; // [RULE_02]

   // index of the last byte step from the write width
   wire [1:0] f_last = (f_item.size == crce_pkg::CRCE_SZ_BYTE) ? crce_pkg::CRCE_LAST_BYTE :
                       (f_item.size == crce_pkg::CRCE_SZ_HALF) ? crce_pkg::CRCE_LAST_HALF :
                       crce_pkg::CRCE_LAST_WORD; // [RULE_09] [RULE_05] [RULE_06] [RULE_07]

   wire running = (state_q == CRCE_RUN);
   wire last_step = running && (idx_q == last_q);
   // the next word is taken in the cycle of the previous word's last byte, so a
   // stream keeps the byte engine busy every cycle
   assign f_pop = f_valid && (!running || last_step); // [RULE_08]
   wire [4:0] byte_sh = {idx_q, 3'b000};
   wire [31:0] word_sh = word_q >> byte_sh;
   wire [7:0] cur_byte = word_sh[7:0]; // [RULE_11]

   // seed and reads only when nothing is queued or in flight, so the sum is final
   assign seed_ready = !running && !f_valid; // [RULE_10] [RULE_11]
   assign rd_ready = !running && !f_valid; // [RULE_10]
   wire seed_take = seed_valid && seed_ready;

   always_comb begin
      crc_d = crc_q;
      if (seed_take) begin
         crc_d = seed & width_mask; // [RULE_04] [RULE_11]
      end else if (running) begin
         crc_d = crc_step(crc_q, cur_byte, cfg.poly); // [RULE_01] [RULE_05]
      end
   end

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         CRCE_IDLE: if (f_pop) state_d = CRCE_RUN;
         CRCE_RUN: if (last_step && !f_pop) state_d = CRCE_IDLE;
      endcase
   end

   // result conditioning over the active width
   wire [31:0] crc_rev = is32 ? rev32(crc_d) : (rev32(crc_d) >> crce_pkg::CRCE_SHIFT16);
   wire [31:0] out_ord = cfg.out_rev ? crc_rev : crc_d; // [RULE_03]
   wire [31:0] out_val = cfg.out_inv ? (out_ord ^ width_mask) : out_ord; // [RULE_03]

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= CRCE_IDLE;
         crc_q <= crce_pkg::CRCE_RST_SUM;
         result_q <= crce_pkg::CRCE_RST_SUM;
      end else begin
         state_q <= state_d;
         crc_q <= crc_d;
         result_q <= out_val;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         word_q <= '0;
         idx_q <= '0;
         last_q <= '0;
      end else if (f_pop) begin
         word_q <= in_cond;
         idx_q <= '0; // [RULE_11]
         last_q <= f_last; // [RULE_09]
      end else if (running && !last_step) begin
         idx_q <= idx_q + 2'h1; // [RULE_06] [RULE_07]
      end
   end

   assign result = result_q;
   assign busy = running || f_valid;

   // rd_valid needs no logic: a read is simply complete in any cycle with rd_ready high
   wire unused_rd = rd_valid;
endmodule

// ### tb/crce_checksum_engine_test.sv
// crce_checksum_engine_test: self-checking bench of the checksum engine.
// assumes crce_writer as master; sums come from a bit-serial model here.
`timescale 1ns/1ns
module crce_checksum_engine_test;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   crce_pkg::crce_cfg_t cfg = '0;
   logic seed_valid = 1'b0;
   logic [31:0] seed = '0;
   logic rd_valid = 1'b0;
   logic seed_ready, wr_valid, wr_ready, rd_ready, busy;
   logic [31:0] result;
   logic [31:0] sum;
   crce_pkg::crce_item_t wr_item;
   int miscompares = 0;
   int n_compared = 0;
   crce_top i_dut (.clk, .nrst, .cfg, .seed_valid, .seed_ready, .seed, .wr_valid,
      .wr_ready, .wr_item, .rd_valid, .rd_ready, .result, .busy);
   crce_writer i_wr (.clk, .wr_ready, .wr_valid, .wr_item);
   initial forever #5 clk = ~clk;
   function automatic logic [31:0] rev(logic [31:0] x, int w);
      logic [31:0] r;
      r = '0;
      for (int i = 0; i < w; i++) r[i] = x[w-1-i];
      return r;
   endfunction
   function automatic logic [31:0] fold(logic [31:0] s, logic [7:0] b);
      logic [31:0] p;
      p = cfg.poly == crce_pkg::CRCE_POLY_CCITT ? crce_pkg::CRCE_POLY_CCITT_VAL :
         cfg.poly == crce_pkg::CRCE_POLY_16 ? crce_pkg::CRCE_POLY_16_VAL :
         crce_pkg::CRCE_POLY_32_VAL;
      if (cfg.in_rev) b = 8'(rev(32'(b), 8));
      b = b ^ {8{cfg.in_inv}};
      for (int i = 7; i >= 0; i--)
         s = (s << 1) ^ (((cfg.poly[1] ? s[31] : s[15]) ^ b[i]) ? p : 32'h0000_0000);
      return cfg.poly[1] ? s : s & crce_pkg::CRCE_MASK16;
   endfunction
   function automatic logic [31:0] cond(logic [31:0] s);
      if (cfg.out_rev) s = rev(s, cfg.poly[1] ? 32 : 16);
      if (cfg.out_inv) s = s ^ (cfg.poly[1] ? crce_pkg::CRCE_MASK32 : crce_pkg::CRCE_MASK16);
      return s;
   endfunction
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic timeout;
      miscompares++;
      print_verdict();
   endtask
   task automatic wr(logic [31:0] d, crce_pkg::crce_size_t z, int gap);
      for (int i = 0; i < (z == 0 ? 1 : z == 1 ? 2 : 4); i++)
         sum = fold(sum, d[8*i +: 8]);
      i_wr.put({d, z}, gap);
      if (i_wr.timed_out) timeout();
   endtask
   task automatic load(logic [31:0] v);
      seed_valid = 1'b1;
      seed = v;
      for (int n = 0; seed_ready !== 1'b1; n++) begin
         if (n == 200) timeout();
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      #1 seed_valid = 1'b0;
      sum = cfg.poly[1] ? v : v & crce_pkg::CRCE_MASK16;
   endtask
   task automatic read(string what);
      i_wr.rest(0);
      rd_valid = 1'b1;
      for (int n = 0; rd_ready !== 1'b1; n++) begin
         if (n == 200) timeout();
         @(posedge clk);
         #1;
      end
      check(what, result, cond(sum));
      @(posedge clk);
      #1 rd_valid = 1'b0;
   endtask
   task automatic t_polys;
      for (int k = 0; k < 4; k++) begin
         cfg = '0;
         cfg.poly = crce_pkg::crce_poly_t'(k);
         load(32'h1d0f_5a3c);
         wr(32'h0403_0201, crce_pkg::CRCE_SZ_WORD, 1);
         read("poly");
      end
   endtask
   task automatic t_opts;
      for (int k = 0; k < 32; k++) begin
         cfg = {k[4] ? crce_pkg::CRCE_POLY_32 : crce_pkg::CRCE_POLY_CCITT, k[3:0]};
         load(32'h8e21_b7c4);
         wr(32'hffff_c3a5, crce_pkg::CRCE_SZ_HALF, 1);
         read("options");
      end
   endtask
   task automatic t_stream;
      cfg = '0;
      cfg.poly = crce_pkg::CRCE_POLY_16;
      load(32'h0000_ffff);
      for (int i = 0; i < 19; i++) // fills the fifo, then a slow tail
         wr(32'h9e37_79b9 * (i + 1), crce_pkg::crce_size_t'(i % 4), i > 15 ? 2 : 0);
      read("stream");
      check("held off", 32'(i_wr.stalls != 0), 32'h1);
   endtask
   task automatic t_reseed;
      cfg = {crce_pkg::CRCE_POLY_32, 4'hb};
      load(32'hffff_ffff);
      wr(32'h7e5a_0f11, crce_pkg::CRCE_SZ_WORD, 0);
      i_wr.rest(0);
      check("seed gate", {31'h0, seed_ready}, 32'h0);
      load(32'h0000_00a5);
      wr(32'h0000_0031, crce_pkg::CRCE_SZ_BYTE, 1);
      read("reseed");
   endtask
   initial begin
      repeat (8) @(posedge clk);
      #1 nrst = 1'b1;
      t_polys();
      t_opts();
      t_stream();
      t_reseed();
      print_verdict();
   end
endmodule

// ### tb/crce_properties.sv
// crce_properties: port checks of the checksum engine.
// assumes binding onto crce_top; one clock domain.
`timescale 1ns/1ns
module crce_props (
   input wire logic clk, // clock
   input wire logic nrst, // reset
   input wire crce_pkg::crce_cfg_t cfg, // options
   input wire logic seed_valid, // seed request
   input wire logic seed_ready, // seed taken
   input wire logic [31:0] seed, // seed
   input wire logic wr_valid, // write request
   input wire logic wr_ready, // write taken
   input wire crce_pkg::crce_item_t wr_item, // item
   input wire logic rd_ready, // result final
   input wire logic [31:0] result, // result
   input wire logic busy // pending
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   wire logic tk = wr_valid && wr_ready && !busy;
   wire logic sk = seed_valid && seed_ready && cfg.poly[1] && !cfg.out_rev;
   ready_idle_a: assert property (
      rd_ready == !busy && seed_ready == rd_ready) else $error("ready vs busy");
   byte_step_a: assert property (
      tk && wr_item.size == crce_pkg::CRCE_SZ_BYTE ##1 !wr_valid [*2] |-> busy ##1 !busy)
      else $error("byte length");
   half_step_a: assert property (
      tk && wr_item.size == crce_pkg::CRCE_SZ_HALF ##1 !wr_valid [*3] |-> busy ##1 !busy)
      else $error("half length");
   word_step_a: assert property (
      tk && wr_item.size == crce_pkg::CRCE_SZ_WORD ##1 !wr_valid [*5] |-> busy ##1 !busy)
      else $error("word length");
   result_hold_a: assert property (
      rd_ready && $past(rd_ready) && !$past(seed_valid) |-> $stable(result))
      else $error("idle result moved");
   seed_load_a: assert property (
      sk && !cfg.out_inv |=> result == $past(seed)) else $error("seed load");
   seed_inv_a: assert property (
      sk && cfg.out_inv |=> result == ~$past(seed)) else $error("seed invert");
   upper_zero_a: assert property (
      seed_valid && seed_ready && !cfg.poly[1] |=> result[31:16] == 16'h0000)
      else $error("upper half set");
endmodule
bind crce_top crce_props i_props (.clk, .nrst, .cfg, .seed_valid, .seed_ready, .seed,
   .wr_valid, .wr_ready, .wr_item, .rd_ready, .result, .busy);

// ### tb/crce_writer.sv
// crce_writer: bus master model streaming data writes.
// assumes its tasks are entered just after a rising edge.
`timescale 1ns/1ns
module crce_writer (
   input wire logic clk, // clock
   input wire logic wr_ready, // write taken
   output logic wr_valid, // write request
   output crce_pkg::crce_item_t wr_item // item
);
   logic timed_out = 1'b0;
   int stalls = 0;
   initial begin
      wr_valid = 1'b0;
      wr_item = '0;
   end
   // released data flips to the inverse of what it held, so a second release shows the last word again
   task automatic rest(input int n);
      wr_valid = 1'b0;
      wr_item.data = ~wr_item.data;
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic put(input crce_pkg::crce_item_t it, input int gap);
      int n;
      if (gap > 0) rest(gap);
      wr_valid = 1'b1;
      wr_item = it;
      for (n = 0; !wr_ready && n < 200; n++) begin
         @(posedge clk);
         #1 stalls++;
      end
      timed_out = n == 200;
      @(posedge clk);
      #1;
   endtask
endmodule
